// ---- lbc_pkg.sv ----
// lbc_pkg.sv: shared constants and types for the bank command checker
package lbc_pkg;

    // ****************************************************************
    // clocking and timing
    // ****************************************************************
    localparam int CLK_NS    = 40;
    localparam int CNT_W     = 8;
    localparam int T_RCD_NS  = 18;
    localparam int T_RP_NS   = 18;
    localparam int T_RRD_NS  = 60;
    localparam int T_INIT_NS = 10000;
    localparam int MRR_NUM   = 2;
    localparam int MRW_NUM   = 5;
    localparam int BURST_NUM = 2;

    // least times round up to whole cycles
    localparam logic [CNT_W-1:0] RCD_CYC =
        CNT_W'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RP_CYC =
        CNT_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RRD_CYC =
        CNT_W'((T_RRD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] INIT_CYC =
        CNT_W'((T_INIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] MRR_CYC   = CNT_W'(MRR_NUM);
    localparam logic [CNT_W-1:0] MRW_CYC   = CNT_W'(MRW_NUM);
    localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_NUM);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;

    // ****************************************************************
    // commands and states
    // ****************************************************************
    typedef enum logic [3:0] {
        LBC_NOP   = 4'h0,
        LBC_ACT   = 4'h1,
        LBC_RD    = 4'h2,
        LBC_WR    = 4'h3,
        LBC_PRE   = 4'h4,
        LBC_BST   = 4'h5,
        LBC_MRR   = 4'h6,
        LBC_MRW   = 4'h7,
        LBC_RESET = 4'h8,
        LBC_REF   = 4'h9
    } lbc_cmd_t;

    typedef enum logic [2:0] {
        B_IDLE     = 3'h0,
        B_ACTIVATE = 3'h1,
        B_ACTIVE   = 3'h3,
        B_READ     = 3'h2,
        B_WRITE    = 3'h6,
        B_READ_AP  = 3'h7,
        B_WRITE_AP = 3'h5,
        B_PRECHG   = 3'h4
    } lbc_bank_t;

    typedef enum logic [2:0] {
        G_POWER_ON = 3'h0,
        G_RESETING = 3'h1,
        G_NORMAL   = 3'h3,
        G_MR_READ  = 3'h2,
        G_MR_WRITE = 3'h6,
        G_RST_MRR  = 3'h7
    } lbc_glob_t;

    localparam lbc_bank_t BANK_RST = B_IDLE;
    localparam lbc_glob_t GLOB_RST = G_POWER_ON;

endpackage : lbc_pkg

// ---- lbc_sync2.sv ----
// lbc_sync2.sv: two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module lbc_sync2
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta_ff  <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_ff  <= nxt_meta;
            sync_out <= nxt_sync;
        end
    end
endmodule : lbc_sync2
`default_nettype wire

// ---- lbc_checker.sv ----
// lbc_checker.sv: bank state tracker, command checker, masked write path
`timescale 1ns/10ps
`default_nettype none
module lbc_checker
    import lbc_pkg::*;
#(
    parameter int NB   = 4,
    parameter int DQ_W = 16
)
(
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     link_clock,
    input  wire logic                     cke,
    input  wire lbc_cmd_t                 cmd,
    input  wire logic [$clog2(NB)-1:0]    cmd_bank,
    input  wire logic                     cmd_ap,
    input  wire logic                     cmd_all,
    output logic                          cmd_error,
    output logic      [NB*3-1:0]          bank_state,
    output lbc_glob_t                     glob_state,
    output logic                          burst_active,
    input  wire logic [DQ_W-1:0]          link_wdata,
    input  wire logic [DQ_W/8-1:0]        write_byte_mask,
    input  wire logic                     link_beat_valid,
    output logic                          link_ready,
    output logic      [DQ_W-1:0]          stored_word,
    output logic                          stored_strobe
);
    localparam int BA_W = $clog2(NB);
    localparam int NBY  = DQ_W / 8;

    if (NB < 2 || (1 << BA_W) != NB || DQ_W < 8 || DQ_W % 8 != 0)
        $error("lbc_checker: unsupported bank count or data width");

    function automatic logic can_pre(input lbc_bank_t s);
        return (s == B_IDLE) || (s == B_ACTIVE) || (s == B_PRECHG);
    endfunction : can_pre

    function automatic logic in_burst(input lbc_bank_t s);
        return (s == B_READ) || (s == B_WRITE) ||
               (s == B_READ_AP) || (s == B_WRITE_AP);
    endfunction : in_burst

    // ****************************************************************
    // command side state
    // ****************************************************************
    lbc_bank_t          bank_ff  [NB];
    lbc_bank_t          nxt_bank [NB];
    logic [CNT_W-1:0]   cnt_ff   [NB];
    logic [CNT_W-1:0]   nxt_cnt  [NB];
    lbc_glob_t          glob_ff, nxt_glob;
    logic [CNT_W-1:0]   gcnt_ff, nxt_gcnt;
    logic [CNT_W-1:0]   init_ff, nxt_init;
    logic [CNT_W-1:0]   rrd_ff, nxt_rrd;
    logic [BA_W-1:0]    bb_ff, nxt_bb;
    logic               cke_prev_ff, nxt_cke_prev;
    logic               err_ff, nxt_err;
    logic               all_idle, burst_on, rd_any, wr_any, all_pre;
    logic               ok;
    logic               req_sync, req_seen_ff, nxt_req_seen;
    logic [DQ_W-1:0]    word_ff, nxt_word;
    logic               strobe_ff, nxt_strobe;

    // ****************************************************************
    // link side state
    // ****************************************************************
    logic               req_ff, nxt_req;
    logic               ack_sync;
    logic [DQ_W-1:0]    ldata_ff, nxt_ldata;
    logic [NBY-1:0]     lben_ff, nxt_lben;

    always_comb
    begin
        all_idle = 1'b1;
        all_pre  = 1'b1;
        rd_any   = 1'b0;
        wr_any   = 1'b0;
        for (int i = 0; i < NB; i++)
        begin
            all_idle = all_idle && (bank_ff[i] == B_IDLE);
            all_pre  = all_pre && can_pre(bank_ff[i]);
            rd_any   = rd_any || bank_ff[i] == B_READ ||
                       bank_ff[i] == B_READ_AP;
            wr_any   = wr_any || bank_ff[i] == B_WRITE ||
                       bank_ff[i] == B_WRITE_AP;
        end
        burst_on = in_burst(bank_ff[bb_ff]);
    end

    always_comb
    begin
        nxt_bank     = bank_ff;
        nxt_cnt      = cnt_ff;
        nxt_glob     = glob_ff;
        nxt_gcnt     = gcnt_ff;
        nxt_init     = init_ff;
        nxt_bb       = bb_ff;
        nxt_cke_prev = cke;
        nxt_rrd      = (rrd_ff != CNT_ZERO) ? rrd_ff - CNT_ONE : rrd_ff;
        // timers run on every edge, mode register accesses included
        for (int i = 0; i < NB; i++)
        begin
            if (bank_ff[i] != B_IDLE && bank_ff[i] != B_ACTIVE)
            begin
                if (cnt_ff[i] != CNT_ZERO)
                    nxt_cnt[i] = cnt_ff[i] - CNT_ONE;
                else
                begin
                    case (bank_ff[i])
                        B_ACTIVATE: nxt_bank[i] = B_ACTIVE;
                        B_READ, B_WRITE: nxt_bank[i] = B_ACTIVE;
                        B_READ_AP, B_WRITE_AP:
                        begin
                            nxt_bank[i] = B_PRECHG;
                            nxt_cnt[i]  = RP_CYC - CNT_ONE;
                        end
                        default: nxt_bank[i] = B_IDLE;
                    endcase
                end
            end
        end
        case (glob_ff)
            G_MR_READ, G_MR_WRITE, G_RST_MRR:
            begin
                if (gcnt_ff != CNT_ZERO)
                    nxt_gcnt = gcnt_ff - CNT_ONE;
                else
                    nxt_glob = (glob_ff == G_RST_MRR) ?
                               G_RESETING : G_NORMAL;
            end
            default: ;
        endcase
        if (glob_ff == G_RESETING || glob_ff == G_RST_MRR)
        begin
            if (init_ff != CNT_ZERO)
                nxt_init = init_ff - CNT_ONE;
            else if (glob_ff == G_RESETING)
                nxt_glob = G_NORMAL;
        end
        ok = 1'b0;
        // every non-nop needs cke high on this and the previous edge
        case (cmd)
            LBC_NOP: ok = 1'b1;
            LBC_ACT:
            begin
                ok = glob_ff == G_NORMAL && bank_ff[cmd_bank] == B_IDLE
                     && rrd_ff == CNT_ZERO;
                if (ok && cke && cke_prev_ff)
                begin
                    nxt_bank[cmd_bank] = B_ACTIVATE;
                    nxt_cnt[cmd_bank]  = RCD_CYC - CNT_ONE;
                    nxt_rrd            = RRD_CYC - CNT_ONE;
                end
            end
            LBC_RD, LBC_WR:
            begin
                ok = glob_ff == G_NORMAL &&
                     (bank_ff[cmd_bank] == B_ACTIVE ||
                      bank_ff[cmd_bank] == B_READ ||
                      bank_ff[cmd_bank] == B_WRITE) &&
                     !((cmd == LBC_WR) ? rd_any : wr_any);
                if (ok && cke && cke_prev_ff)
                begin
                    // a new burst cuts the running one short
                    if (burst_on)
                    begin
                        if (bank_ff[bb_ff] == B_READ_AP ||
                            bank_ff[bb_ff] == B_WRITE_AP)
                        begin
                            nxt_bank[bb_ff] = B_PRECHG;
                            nxt_cnt[bb_ff]  = RP_CYC - CNT_ONE;
                        end
                        else
                            nxt_bank[bb_ff] = B_ACTIVE;
                    end
                    if (cmd == LBC_RD)
                        nxt_bank[cmd_bank] = cmd_ap ? B_READ_AP
                                                    : B_READ;
                    else
                        nxt_bank[cmd_bank] = cmd_ap ? B_WRITE_AP
                                                    : B_WRITE;
                    nxt_cnt[cmd_bank] = BURST_CYC - CNT_ONE;
                    nxt_bb            = cmd_bank;
                end
            end
            LBC_PRE:
            begin
                ok = glob_ff == G_NORMAL &&
                     (cmd_all ? all_pre
                              : can_pre(bank_ff[cmd_bank]));
                if (ok && cke && cke_prev_ff)
                begin
                    for (int i = 0; i < NB; i++)
                    begin
                        if (cmd_all || cmd_bank == BA_W'(i))
                        begin
                            nxt_bank[i] = B_PRECHG;
                            nxt_cnt[i]  = RP_CYC - CNT_ONE;
                        end
                    end
                end
            end
            LBC_BST:
            begin
                ok = glob_ff == G_NORMAL && burst_on
                     && cmd_bank == bb_ff;
                if (ok && cke && cke_prev_ff)
                begin
                    if (bank_ff[bb_ff] == B_READ_AP ||
                        bank_ff[bb_ff] == B_WRITE_AP)
                    begin
                        nxt_bank[bb_ff] = B_PRECHG;
                        nxt_cnt[bb_ff]  = RP_CYC - CNT_ONE;
                    end
                    else
                        nxt_bank[bb_ff] = B_ACTIVE;
                end
            end
            LBC_MRR:
            begin
                ok = (glob_ff == G_NORMAL && !burst_on) ||
                     glob_ff == G_RESETING;
                if (ok && cke && cke_prev_ff)
                begin
                    nxt_glob = (glob_ff == G_RESETING) ? G_RST_MRR
                                                       : G_MR_READ;
                    nxt_gcnt = MRR_CYC - CNT_ONE;
                end
            end
            LBC_MRW:
            begin
                ok = glob_ff == G_NORMAL && all_idle;
                if (ok && cke && cke_prev_ff)
                begin
                    nxt_glob = G_MR_WRITE;
                    nxt_gcnt = MRW_CYC - CNT_ONE;
                end
            end
            LBC_RESET:
            begin
                ok = glob_ff == G_POWER_ON ||
                     (glob_ff == G_NORMAL && all_idle);
                if (ok && cke && cke_prev_ff)
                begin
                    nxt_glob = G_RESETING;
                    nxt_init = INIT_CYC - CNT_ONE;
                    for (int i = 0; i < NB; i++)
                        nxt_bank[i] = B_IDLE;
                end
            end
            LBC_REF: ok = glob_ff == G_NORMAL && all_idle;
            default: ok = 1'b0;
        endcase
        // busy global states fall out above as not normal
        nxt_err = !(ok && (cke && cke_prev_ff || cmd == LBC_NOP));
    end

    // ****************************************************************
    // write beats: link domain holds a beat until the core acks it
    // ****************************************************************
    always_comb
    begin
        link_ready = (req_ff == ack_sync);
        nxt_req    = req_ff;
        nxt_ldata  = ldata_ff;
        nxt_lben   = lben_ff;
        if (link_beat_valid && link_ready)
        begin
            nxt_req   = !req_ff;
            nxt_ldata = link_wdata;
            nxt_lben  = ~write_byte_mask;
        end
    end

    always_comb
    begin
        nxt_req_seen = req_sync;
        nxt_word     = word_ff;
        nxt_strobe   = 1'b0;
        // link data is stable while the request toggle is unacked
        if (req_sync != req_seen_ff && wr_any)
        begin
            for (int j = 0; j < NBY; j++)
                if (lben_ff[j])
                    nxt_word[j*8 +: 8] = ldata_ff[j*8 +: 8];
            nxt_strobe = 1'b1;
        end
    end

    lbc_sync2 u_req_sync
    (
        .clock    (clock),
        .rst      (rst),
        .async_in (req_ff),
        .sync_out (req_sync)
    );

    lbc_sync2 u_ack_sync
    (
        .clock    (link_clock),
        .rst      (rst),
        .async_in (req_seen_ff),
        .sync_out (ack_sync)
    );

    always_ff @(posedge link_clock or posedge rst)
    begin
        if (rst)
        begin
            req_ff   <= 1'b0;
            ldata_ff <= '0;
            lben_ff  <= '0;
        end
        else
        begin
            req_ff   <= nxt_req;
            ldata_ff <= nxt_ldata;
            lben_ff  <= nxt_lben;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NB; i++)
            begin
                bank_ff[i] <= BANK_RST;
                cnt_ff[i]  <= CNT_ZERO;
            end
            glob_ff     <= GLOB_RST;
            gcnt_ff     <= CNT_ZERO;
            init_ff     <= CNT_ZERO;
            rrd_ff      <= CNT_ZERO;
            bb_ff       <= '0;
            cke_prev_ff <= 1'b0;
            err_ff      <= 1'b0;
            req_seen_ff <= 1'b0;
            word_ff     <= '0;
            strobe_ff   <= 1'b0;
        end
        else
        begin
            bank_ff     <= nxt_bank;
            cnt_ff      <= nxt_cnt;
            glob_ff     <= nxt_glob;
            gcnt_ff     <= nxt_gcnt;
            init_ff     <= nxt_init;
            rrd_ff      <= nxt_rrd;
            bb_ff       <= nxt_bb;
            cke_prev_ff <= nxt_cke_prev;
            err_ff      <= nxt_err;
            req_seen_ff <= nxt_req_seen;
            word_ff     <= nxt_word;
            strobe_ff   <= nxt_strobe;
        end
    end

    for (genvar g = 0; g < NB; g++)
    begin : g_state
        assign bank_state[g*3 +: 3] = bank_ff[g];
    end

    assign cmd_error     = err_ff;
    assign glob_state    = glob_ff;
    assign burst_active  = burst_on;
    assign stored_word   = word_ff;
    assign stored_strobe = strobe_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    localparam int MRW_DLY = MRW_NUM + 1;
    logic act_ok;
    assign act_ok = cmd == LBC_ACT && !nxt_err;

    a_nop_no_error: assert property (@(posedge clock) disable iff (rst)
        cmd == LBC_NOP |=> !cmd_error)
        else $error("nop was flagged");
    a_act_idle_only: assert property (@(posedge clock) disable iff (rst)
        cmd == LBC_ACT && bank_ff[cmd_bank] != B_IDLE |=> cmd_error)
        else $error("activate to busy bank not flagged");
    a_rrd_spacing: assert property (@(posedge clock) disable iff (rst)
        act_ok ##1 cmd == LBC_ACT |=> cmd_error)
        else $error("activate inside tRRD not flagged");
    a_bst_in_burst: assert property (@(posedge clock) disable iff (rst)
        cmd == LBC_BST && !burst_on |=> cmd_error)
        else $error("stray burst terminate not flagged");
    a_mrw_all_idle: assert property (@(posedge clock) disable iff (rst)
        cmd == LBC_MRW && !all_idle |=> cmd_error)
        else $error("mode write with busy bank not flagged");
    a_mrw_returns: assert property (@(posedge clock) disable iff (rst)
        glob_ff == G_NORMAL && cmd == LBC_MRW && !nxt_err
        |-> ##MRW_DLY glob_ff == G_NORMAL)
        else $error("mode write did not return to idle");
    a_cke_gate: assert property (@(posedge clock) disable iff (rst)
        !(cke && cke_prev_ff) && cmd != LBC_NOP |=> cmd_error)
        else $error("command with low cke not flagged");
    a_mr_busy_nop: assert property (@(posedge clock) disable iff (rst)
        (glob_ff == G_MR_READ || glob_ff == G_MR_WRITE) && cmd != LBC_NOP
        |=> cmd_error)
        else $error("command during mode access not flagged");
    a_act_opens: assert property (@(posedge clock) disable iff (rst)
        act_ok && cmd_bank == '0 |=> bank_ff[0] == B_ACTIVATE)
        else $error("activate did not open bank");
    a_pre_waits: assert property (@(posedge clock) disable iff (rst)
        cmd == LBC_PRE && !nxt_err && (cmd_all || cmd_bank == '0)
        |=> bank_ff[0] == B_PRECHG)
        else $error("precharge skipped tRP");
    a_mask_store: assert property (@(posedge link_clock) disable iff (rst)
        link_beat_valid && link_ready |=> lben_ff == ~$past(write_byte_mask))
        else $error("byte enables do not follow mask");

    c_act: cover property (@(posedge clock) disable iff (rst) act_ok);
    c_bst: cover property (@(posedge clock) disable iff (rst)
        cmd == LBC_BST && !nxt_err);
    c_mrr: cover property (@(posedge clock) disable iff (rst)
        glob_ff == G_MR_READ);
    c_beat: cover property (@(posedge clock) disable iff (rst) strobe_ff);
endmodule : lbc_checker
`default_nettype wire

// ---- lbc_ctrl_model.sv ----
// lbc_ctrl_model.sv: controller model offering write beats on the link
`timescale 1ns/10ps
`default_nettype none
module lbc_ctrl_model
(
    input  wire logic        link_ready,
    output logic             link_clock,
    output logic [15:0]      link_wdata,
    output logic [1:0]       write_byte_mask,
    output logic             link_beat_valid
);
    initial
    begin
        link_clock      = 1'b0;
        link_wdata      = 16'h0000;
        write_byte_mask = 2'h0;
        link_beat_valid = 1'b0;
    end
    // link clock runs only within a frame and idles low
    task automatic send(input logic [15:0] d, input logic [1:0] m);
        logic rdy;
        logic low;
        low             = 1'b0;
        link_wdata      = d;
        write_byte_mask = m;
        link_beat_valid = 1'b1;
        for (int n = 0; n < 40; n++)
        begin
            #32;
            rdy        = link_ready;
            link_clock = 1'b1;
            #1;
            // released lines show the inverse, never a stale copy
            if (link_beat_valid && rdy)
            begin
                link_beat_valid = 1'b0;
                link_wdata      = ~d;
                write_byte_mask = ~m;
            end
            else if (!rdy)
                low = 1'b1;
            else if (low)
                n = 40;
            #31;
            link_clock = 1'b0;
        end
    endtask : send
endmodule : lbc_ctrl_model
`default_nettype wire

// ---- tb_lpddr2_bank_command_checker.sv ----
// tb_lpddr2_bank_command_checker.sv: self-checking bench for lbc_checker
`timescale 1ns/10ps
`default_nettype none
module tb_lpddr2_bank_command_checker
    import lbc_pkg::*;
;
    // ****************************************
    // stimulus, design and partner
    // ****************************************
    logic        clock    = 1'b0;
    logic        rst      = 1'b1;
    logic        cke      = 1'b1;
    lbc_cmd_t    cmd      = LBC_NOP;
    logic [1:0]  cmd_bank = 2'h0;
    logic        cmd_ap   = 1'b0;
    logic        cmd_all  = 1'b0;
    logic        cmd_error, burst_active, link_clock, link_beat_valid;
    logic        link_ready, stored_strobe;
    logic [11:0] bank_state;
    lbc_glob_t   glob_state;
    logic [15:0] link_wdata, stored_word;
    logic [1:0]  write_byte_mask;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    int          cyc        = 0;
    logic [39:0] r;
    // row: cke cmd _ bank ap/all wait err _ glob bank_state
    localparam logic [39:0] TBL [30] = '{
        40'h11_0000_3001, 40'h11_1001_3003, 40'h11_1000_300b,
        40'h10_0000_301b, 40'h12_0000_301a, 40'h13_1001_301a,
        40'h10_0030_301b, 40'h13_1200_302b, 40'h15_0001_302b,
        40'h12_0041_3003, 40'h14_0000_3004, 40'h14_2000_3100,
        40'h17_0001_3000, 40'h17_0000_6000, 40'h11_0031_6000,
        40'h10_0000_3000, 40'h15_0001_3000, 40'h11_3000_3200,
        40'h16_0000_2600, 40'h10_0010_3600, 40'h14_0100_3924,
        40'h10_0000_3000, 40'h19_0000_3000, 40'h01_0001_3000,
        40'h11_0001_3000, 40'h11_0010_3003, 40'h11_1010_301b,
        40'h12_1200_303b, 40'h12_0000_3022, 40'h15_0000_3003
    };
    always #20 clock = ~clock;
    lbc_checker lbc_checker_i (.clock, .rst, .link_clock, .cke, .cmd,
        .cmd_bank, .cmd_ap, .cmd_all, .cmd_error, .bank_state, .glob_state,
        .burst_active, .link_wdata, .write_byte_mask, .link_beat_valid,
        .link_ready, .stored_word, .stored_strobe);
    lbc_ctrl_model lbc_ctrl_model_i (.link_ready, .link_clock, .link_wdata,
        .write_byte_mask, .link_beat_valid);
    // ****************************************
    // compare, drive and closing tasks
    // ****************************************
    task automatic wrap_up;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_vec
    task automatic chk_bit(input logic got, input logic exp);
        chk_vec(16'(got), 16'(exp));
    endtask : chk_bit
    task automatic issue(input logic c, input lbc_cmd_t k,
                         input logic [1:0] b, input logic ap, input logic al);
        cke      = c;
        cmd      = k;
        cmd_bank = b;
        cmd_ap   = ap;
        cmd_all  = al;
        @(negedge clock);
    endtask : issue
    task automatic cmd1(input lbc_cmd_t k);
        issue(1'b1, k, 2'h0, 1'b0, 1'b0);
    endtask : cmd1
    task automatic beat(input logic [15:0] d, input logic [1:0] m,
                        input logic wr, input logic [15:0] exp);
        logic seen;
        seen = 1'b0;
        fork
            lbc_ctrl_model_i.send(d, m);
            for (int n = 0; n < 40; n++)
            begin
                cmd = (wr && n < 30) ? LBC_WR : LBC_NOP;
                @(negedge clock);
                seen = seen | stored_strobe;
                if (n == 8)
                    chk_bit(burst_active, wr);
            end
        join
        chk_bit(seen, wr);
        chk_vec(stored_word, exp);
    endtask : beat
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            wrap_up;
        end
    end
    initial
    begin
        repeat (16) @(negedge clock);
        chk_vec(16'(bank_state), 16'h0000);
        chk_vec(16'(glob_state), 16'(G_POWER_ON));
        chk_vec(stored_word, 16'h0000);
        chk_bit(link_ready & ~stored_strobe & ~cmd_error, 1'b1);
        rst = 1'b0;
        cmd1(LBC_NOP);
        cmd1(LBC_ACT);
        chk_bit(cmd_error, 1'b1);
        cmd1(LBC_RESET);
        chk_vec(16'(glob_state), 16'(G_RESETING));
        cmd1(LBC_MRR);
        chk_vec(16'(glob_state), 16'(G_RST_MRR));
        cmd1(LBC_NOP);
        cmd1(LBC_NOP);
        chk_vec(16'(glob_state), 16'(G_RESETING));
        for (int i = 0; i < 300 && glob_state !== G_NORMAL; i++)
            cmd1(LBC_NOP);
        chk_vec(16'(glob_state), 16'(G_NORMAL));
        foreach (TBL[i])
        begin
            r = TBL[i];
            issue(r[36], lbc_cmd_t'(r[35:32]), r[29:28], r[25], r[24]);
            chk_bit(cmd_error, r[16]);
            repeat (r[23:20]) cmd1(LBC_NOP);
            chk_vec(16'(glob_state), 16'(r[14:12]));
            chk_vec(16'(bank_state), 16'(r[11:0]));
        end
        beat(16'h1234, 2'h0, 1'b1, 16'h1234);
        beat(16'habcd, 2'h1, 1'b1, 16'hab34);
        beat(16'h5555, 2'h0, 1'b0, 16'hab34);
        // reset in mid-run: state clears, first edge after release refuses
        rst = 1'b1;
        repeat (2) @(negedge clock);
        chk_vec(16'(bank_state), 16'h0000);
        chk_vec(16'(glob_state), 16'(G_POWER_ON));
        chk_vec(stored_word, 16'h0000);
        rst = 1'b0;
        cmd1(LBC_RESET);
        chk_bit(cmd_error, 1'b1);
        cmd1(LBC_RESET);
        chk_vec(16'(glob_state), 16'(G_RESETING));
        wrap_up;
    end
endmodule : tb_lpddr2_bank_command_checker
`default_nettype wire
